// ### common/buck_pwm_pkg.sv
// Purpose: types for the buck switching control block
// Assumes: nothing beyond the constants header
// Notes:   modes and switching states
package buck_pwm_pkg;

  typedef enum logic [1:0] {
    MODE_AUTO_SKIP,
    MODE_ULTRASONIC,
    MODE_FORCED_PWM
  } mode_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HIGH_ON,
    ST_LOW_ON,
    ST_ULTRA_LOW,
    ST_DEAD_TO_HIGH,
    ST_DEAD_TO_LOW
  } sw_state_e;

endpackage

// ### common/buck_pwm_regs.svh
// Purpose: constants for the buck switching control block
// Assumes: system clock of 40 MHz
// Notes:   times are kept in their own unit, cycle counts derived from them
`ifndef BUCK_PWM_REGS_SVH
`define BUCK_PWM_REGS_SVH

`define SYS_CLK_HZ        40000000
`define SYS_CLK_PERIOD_NS 25
// switching clock frequency in hertz
`define SW_FREQ_HZ        300000
// switching period in system cycles (rounded down: a longest time)
`define SW_PERIOD_CYC     (`SYS_CLK_HZ / `SW_FREQ_HZ)
// ultrasonic idle time in nanoseconds
`define IDLE_TIME_NS      30000
// idle count, least time rounded up
`define IDLE_CYC          ((`IDLE_TIME_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
// minimum effective frequency in ultrasonic mode
`define MIN_FREQ_HZ       25000
// mode input codes
`define MODE_IN_GND       2'h0
`define MODE_IN_REF       2'h1
`define MODE_IN_VCC       2'h2
`define MODE_IN_RESET     2'h0

`endif

// ### rtl/buck_pwm_mode_control.sv
// Functional notes
// RULE1: high side on each clock edge until trip
// RULE2: off portion: high side off, low on
// RULE3: overcurrent ends the on-time at once
// RULE4: overcurrent at clock edge skips pulse
// RULE5: auto skip: zero crossing releases low side
// RULE6: auto skip: skip limit, omit pulses
// RULE7: skip modes switch at constant frequency
// RULE8: ultrasonic: low side after 30us idle
// RULE9: ultrasonic: negative limit or trip starts pulse
// RULE10: idle timer keeps switching above 25kHz
// RULE11: forced pwm ignores zero crossing
// RULE12: forced pwm: low held until next clock
// RULE13: 300kHz switching clock, channels 180 degrees apart
// RULE14: dead time until other gate sensed off
// RULE15: decode mode, hold it through a cycle; the code also takes a new mode mid-cycle while the channel is idle
//
// Purpose: gate sequencing for two step-down channels
// Assumes: comparator flags and gate sense inputs are synchronous to clk_sys
// Notes:   one sequencer per channel, generated; gates only leave flip-flops
//          mode code 3 is taken as forced pwm
`timescale 1ns/10ps
`include "buck_pwm_regs.svh"
module buck_pwm_mode_control
  import buck_pwm_pkg::*;
#(
  parameter int PERIOD_CYC = `SW_PERIOD_CYC,
  parameter int IDLE_CYC   = `IDLE_CYC
) (
  input  wire logic       clk_sys,          // system clock, 40 MHz
  input  wire logic       rst,              // synchronous reset, active high
  input  wire logic [1:0] mode_level,       // three-level mode input, coded
  input  wire logic [1:0] loop_trip,        // ramp crossed error level
  input  wire logic [1:0] over_current,     // positive current limit
  input  wire logic [1:0] zero_cross,       // inductor current at zero
  input  wire logic [1:0] neg_limit,        // negative current limit
  input  wire logic [1:0] skip_limit,       // skip current threshold reached
  input  wire logic [1:0] error_low,        // error level low, pulse may be omitted
  input  wire logic [1:0] high_sensed_off,  // high gate sensed fully off
  input  wire logic [1:0] low_sensed_off,   // low gate sensed fully off
  output logic      [1:0] high_side_gate,   // high side gate drive
  output logic      [1:0] low_side_gate,    // low side gate drive
  output logic      [1:0] mode_active       // decoded mode of channel 0
);

  // idle counter wide enough for the full idle count
  localparam int IW = $clog2(IDLE_CYC + 1);
  localparam logic [IW-1:0] IDLE_LAST = IW'(IDLE_CYC - 1);

  // decode the three-level input; undefined code falls back to forced pwm
  function automatic mode_e decode_mode(input logic [1:0] lvl);
    if (lvl == `MODE_IN_GND) begin
      return MODE_AUTO_SKIP;
    end else if (lvl == `MODE_IN_REF) begin
      return MODE_ULTRASONIC;
    end else begin
      return MODE_FORCED_PWM;
    end
  endfunction

  // live decode; each channel takes it at a cycle boundary or while it is idle
  wire  mode_e live_mode = decode_mode(mode_level);
  wire  [1:0]  sw_edge;

  // RULE13 shared clock, two phases
  // both channels share one counter so their phases can never drift apart
  switch_clock_gen #(
    .PERIOD_CYC (PERIOD_CYC)
  ) u_clk (
    .clk_sys (clk_sys),
    .rst     (rst),
    .edge_a  (sw_edge[0]),
    .edge_b  (sw_edge[1])
  );

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      sw_state_e      state;
      sw_state_e      next_state;
      mode_e          mode;
      logic [IW-1:0]  idle_cnt;
      logic           ultra_pulse;

      wire clk_edge = sw_edge[ch];
      wire trip     = loop_trip[ch];
      wire oc       = over_current[ch];
      wire idle_out = (idle_cnt == IDLE_LAST);
      // RULE6 auto skip ends pulse at skip limit
      wire skip_end = (mode == MODE_AUTO_SKIP) && skip_limit[ch];
      // RULE7 skip threshold ends pulse, ultrasonic too
      wire skip_thr = (mode == MODE_ULTRASONIC) && skip_limit[ch];
      // RULE6 omit pulse while error stays low, in both skip modes;
      // without skipping the ultrasonic idle timer could never run out
      wire omit     = (mode != MODE_FORCED_PWM) && error_low[ch];
      // RULE5 zero crossing releases low side; RULE11 not in forced pwm
      wire zc_off   = (mode != MODE_FORCED_PWM) && zero_cross[ch];
      // RULE9 ultrasonic low pulse ends on limit or trip
      wire ultra_end = neg_limit[ch] || trip;
      wire leaving_high = trip || oc || skip_end || skip_thr;

      // next state; every entry to a gate waits in a dead state
      // overcurrent is tested before the edge so no pulse starts into a limit
      always_comb begin
        next_state = state;
        case (state)
          ST_IDLE: begin
            // RULE4 overcurrent at edge skips pulse
            if (clk_edge && oc) begin
              next_state = ST_DEAD_TO_LOW;
            // RULE1 clock edge starts on-time
            end else if (clk_edge && !omit) begin
              next_state = ST_DEAD_TO_HIGH;
            // RULE8 idle timeout drives low side
            end else if (mode == MODE_ULTRASONIC && idle_out) begin
              next_state = ST_DEAD_TO_LOW;
            end
          end
          ST_DEAD_TO_HIGH: begin
            // RULE14 wait low gate sensed off
            if (oc) begin
              next_state = ST_DEAD_TO_LOW;
            end else if (low_sensed_off[ch]) begin
              next_state = ST_HIGH_ON;
            end
          end
          ST_HIGH_ON: begin
            // RULE3 overcurrent ends pulse
            if (leaving_high) begin
              next_state = ST_DEAD_TO_LOW;
            end
          end
          ST_DEAD_TO_LOW: begin
            // RULE14 wait high gate sensed off
            // no timeout: a stuck sense input parks the channel with both gates off
            if (high_sensed_off[ch]) begin
              next_state = ultra_pulse ? ST_ULTRA_LOW : ST_LOW_ON;
            end
          end
          ST_LOW_ON: begin
            // RULE4 still overcurrent: stay low
            if (clk_edge && oc) begin
              next_state = ST_LOW_ON;
            // RULE12 forced pwm holds low to next edge
            end else if (clk_edge && !omit) begin
              next_state = ST_DEAD_TO_HIGH;
            end else if (zc_off) begin
              next_state = ST_IDLE;
            end
          end
          ST_ULTRA_LOW: begin
            // RULE9 release low, start high pulse
            // a clock edge ends it too, so this low pulse never spans a cycle
            if (ultra_end || clk_edge) begin
              next_state = ST_DEAD_TO_HIGH;
            end
          end
          default: next_state = ST_IDLE;
        endcase
      end

      // RULE2 complementary gates from state
      wire next_high = (next_state == ST_HIGH_ON);
      wire next_low  = (next_state == ST_LOW_ON) || (next_state == ST_ULTRA_LOW);
      // RULE15 mode latched at the cycle boundary or while the channel is idle
      wire take_mode = clk_edge || (state == ST_IDLE);
      // only an idle timeout marks a low pulse that the negative limit may end
      wire next_ultra = (state == ST_IDLE) && (next_state == ST_DEAD_TO_LOW)
                        && !clk_edge;

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          state <= ST_IDLE;
          mode  <= MODE_FORCED_PWM;
        end else begin
          state <= next_state;
          if (take_mode) begin
            mode <= live_mode;
          end
        end
      end

      // RULE10 idle timer restarts on any switching
      // it wraps harmlessly in the other modes; only ultrasonic acts on it
      always_ff @(posedge clk_sys) begin
        if (rst || state != ST_IDLE || idle_out) begin
          idle_cnt <= '0;
        end else begin
          idle_cnt <= idle_cnt + IW'(1);
        end
      end

      // gate and marker flops
      // gates leave flip-flops only, so no decode glitch reaches a driver
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          high_side_gate[ch] <= 1'b0;
          low_side_gate[ch]  <= 1'b0;
          ultra_pulse        <= 1'b0;
        end else begin
          high_side_gate[ch] <= next_high;
          low_side_gate[ch]  <= next_low;
          if (next_ultra) begin
            ultra_pulse <= 1'b1;
          end else if (next_state == ST_DEAD_TO_HIGH) begin
            ultra_pulse <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // channel 0 mode shown for observation
  // limitation: channel 1 decodes the same input but is not shown
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_active <= 2'h0;
    end else begin
      mode_active <= 2'(g_ch[0].mode);
    end
  end

endmodule

// ### rtl/switch_clock_gen.sv
// Purpose: switching clock edge generator for two out-of-phase channels
// Assumes: period parameter is at least two system cycles
// Notes:   one pulse per period per channel, channel b offset by half a period
`timescale 1ns/10ps
module switch_clock_gen #(
  parameter int PERIOD_CYC = 133
) (
  input  wire logic clk_sys,      // system clock
  input  wire logic rst,          // synchronous reset, active high
  output logic      edge_a,       // switching edge, channel a
  output logic      edge_b        // switching edge, channel b
);

  localparam int CW = $clog2(PERIOD_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD_CYC - 1);
  // channel a fires after LAST, so channel b fires after the count one short of half a period
  localparam logic [CW-1:0] HALF = CW'(PERIOD_CYC / 2 - 1);

  logic [CW-1:0] phase_cnt;
  wire  [CW-1:0] next_phase_cnt = (phase_cnt == LAST) ? '0 : phase_cnt + CW'(1);

  // free running phase counter; channel b fires half a period later
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_cnt <= '0;
      edge_a    <= 1'b0;
      edge_b    <= 1'b0;
    end else begin
      phase_cnt <= next_phase_cnt;
      edge_a    <= (phase_cnt == LAST);
      edge_b    <= (phase_cnt == HALF);
    end
  end

endmodule

// ### verification/buck_pwm_assertions.sv
// Purpose: gate sequencing checks on channel 0
// Assumes: sense inputs follow the gates
// Notes:   channel 1 shares the logic and is covered by the bench
`timescale 1ns/10ps
module buck_pwm_checker
  import buck_pwm_pkg::*;
#(
  parameter int PERIOD_CYC = 133,
  parameter int IDLE_CYC   = 1200
) (
  input wire logic       clk_sys,         // system clock
  input wire logic       rst,             // sync reset
  input wire logic [1:0] loop_trip,       // loop comparator
  input wire logic [1:0] over_current,    // current limit
  input wire logic [1:0] zero_cross,      // zero crossing
  input wire logic [1:0] skip_limit,      // skip threshold
  input wire logic [1:0] high_side_gate,  // high gate
  input wire logic [1:0] low_side_gate,   // low gate
  input wire logic [1:0] mode_active      // decoded mode
);
  int idle;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // cycles with both gates off in ultrasonic mode
  always_ff @(posedge clk_sys) begin
    if (rst || high_side_gate[0] || low_side_gate[0] || mode_active != MODE_ULTRASONIC) begin
      idle <= 0;
    end else begin
      idle <= idle + 1;
    end
  end
  sequence s_low_rise;
    ##[1:6] low_side_gate[0];
  endsequence
  property p_excl; !(high_side_gate[0] && low_side_gate[0]); endproperty
  property p_dead; $rose(high_side_gate[0]) |-> !$past(low_side_gate[0]); endproperty
  property p_oc; high_side_gate[0] && over_current[0] |=> !high_side_gate[0]; endproperty
  property p_hold;
    high_side_gate[0] && !loop_trip[0] && !over_current[0] && !skip_limit[0]
      |=> high_side_gate[0];
  endproperty
  property p_oc_low;
    mode_active == MODE_FORCED_PWM && over_current[0] && low_side_gate[0] |=> low_side_gate[0];
  endproperty
  property p_zc;
    mode_active == MODE_AUTO_SKIP && low_side_gate[0] && zero_cross[0] && !over_current[0]
      |-> ##[1:2] !low_side_gate[0];
  endproperty
  property p_off; $fell(high_side_gate[0]) |-> s_low_rise; endproperty
  property p_idle; idle <= IDLE_CYC + 4; endproperty
  property p_mode;
    high_side_gate[0] && $past(high_side_gate[0]) |-> $stable(mode_active) && mode_active != 2'h3;
  endproperty
  a_excl: assert property (p_excl) else $error("both gates on");
  a_dead: assert property (p_dead) else $error("no dead cycle before high");
  a_oc: assert property (p_oc) else $error("overcurrent kept high gate");
  a_hold: assert property (p_hold) else $error("high gate dropped early");
  a_oc_low: assert property (p_oc_low) else $error("low gate left in overcurrent");
  a_zc: assert property (p_zc) else $error("low gate kept past zero");
  a_off: assert property (p_off) else $error("low gate missing after high");
  a_idle: assert property (p_idle) else $error("idle too long");
  a_mode: assert property (p_mode) else $error("mode moved in pulse");
endmodule
bind buck_pwm_mode_control buck_pwm_checker #(.PERIOD_CYC(PERIOD_CYC), .IDLE_CYC(IDLE_CYC)) chk (
  .clk_sys(clk_sys), .rst(rst), .loop_trip(loop_trip), .over_current(over_current),
  .zero_cross(zero_cross), .skip_limit(skip_limit), .high_side_gate(high_side_gate),
  .low_side_gate(low_side_gate), .mode_active(mode_active));

// ### verification/gate_switch_model.sv
// Purpose: external switch pair, reports each gate sensed fully off
// Assumes: gate drives from the block, sampled on clk_sys
// Notes:   slow mode stretches turn-off to stress the dead time wait
`timescale 1ns/10ps
module gate_switch_model (
  input  wire logic       clk_sys,          // system clock
  input  wire logic       slow,             // slow gate discharge
  input  wire logic [1:0] high_side_gate,   // high gate drive
  input  wire logic [1:0] low_side_gate,    // low gate drive
  output logic      [1:0] high_sensed_off,  // high gate fully off
  output logic      [1:0] low_sensed_off    // low gate fully off
);
  logic [1:0] hd1 = '0, hd2 = '0, ld1 = '0, ld2 = '0;
  // gate charge history; sensing lags the drive like a real gate
  always @(posedge clk_sys) begin
    hd1 <= high_side_gate;
    hd2 <= hd1;
    ld1 <= low_side_gate;
    ld2 <= ld1;
  end
  assign high_sensed_off = ~high_side_gate & ~hd1 & ~(hd2 & {2{slow}});
  assign low_sensed_off  = ~low_side_gate & ~ld1 & ~(ld2 & {2{slow}});
endmodule

// ### verification/tb_top.sv
// Purpose: self-checking bench for the buck gate sequencer
// Assumes: short switching period and idle count
// Notes:   pulse counts per window are compared with the period model
`timescale 1ns/10ps
module tb_top;
  localparam int P = 16;
  logic clk_sys = 0, rst = 1, slow = 0;
  logic [1:0] mode_level = 2'h2, loop_trip = 0, over_current = 0, zero_cross = 0;
  logic [1:0] neg_limit = 0, skip_limit = 0, error_low = 0;
  logic [1:0] high_side_gate, low_side_gate, mode_active, high_sensed_off, low_sensed_off;
  logic [1:0] hq = 0;
  int n_fail = 0, checks = 0, seed = 32'h39d2, ontime = 2, cyc = 0, low_gap = 0;
  int rises[2] = '{0, 0}, t_rise[2], on_cnt[2], r0, r1, g0;
  int lo_cnt[2], on_max = 0, lo_max = 0;
  buck_pwm_mode_control #(.PERIOD_CYC(P), .IDLE_CYC(40)) DUT (.clk_sys(clk_sys), .rst(rst),
    .mode_level(mode_level), .loop_trip(loop_trip), .over_current(over_current),
    .zero_cross(zero_cross), .neg_limit(neg_limit), .skip_limit(skip_limit),
    .error_low(error_low), .high_sensed_off(high_sensed_off), .low_sensed_off(low_sensed_off),
    .high_side_gate(high_side_gate), .low_side_gate(low_side_gate), .mode_active(mode_active));
  gate_switch_model sw (.clk_sys(clk_sys), .slow(slow), .high_side_gate(high_side_gate),
    .low_side_gate(low_side_gate), .high_sensed_off(high_sensed_off),
    .low_sensed_off(low_sensed_off));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // loop comparator trips after a random on-time; pulse starts are counted
  always @(negedge clk_sys) begin
    cyc++;
    if (!low_side_gate[0]) low_gap++;
    for (int i = 0; i < 2; i++) begin
      if (high_side_gate[i] && !hq[i]) begin
        rises[i]++;
        t_rise[i] = cyc;
        ontime = 1 + ($random(seed) & 3);
      end
      on_cnt[i] = high_side_gate[i] ? on_cnt[i] + 1 : 0;
      lo_cnt[i] = low_side_gate[i] ? lo_cnt[i] + 1 : 0;
      loop_trip[i] = high_side_gate[i] && on_cnt[i] >= ontime;
      // inductor current reaches the negative limit after three low cycles
      neg_limit[i] = lo_cnt[i] >= 3;
      hq[i] = high_side_gate[i];
    end
    if (on_cnt[0] > on_max) on_max = on_cnt[0];
    if (lo_cnt[0] > lo_max) lo_max = lo_cnt[0];
  end
  function automatic int mode_of(int lvl);
    return (lvl > 2) ? 2 : lvl;
  endfunction
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // settle two periods (a new mode waits for a switching edge unless the channel is idle), then count over n periods
  task automatic window(int n);
    repeat (2 * P) @(posedge clk_sys);
    r0 = rises[0];
    r1 = rises[1];
    g0 = low_gap;
    on_max = 0;
    lo_max = 0;
    repeat (n * P) @(posedge clk_sys);
    r0 = rises[0] - r0;
    r1 = rises[1] - r1;
    g0 = low_gap - g0;
  endtask
  task automatic wrap_up();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clk_sys);
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (2) @(negedge clk_sys);
    rst = 0;
    for (int m = 0; m < 4; m++) begin
      mode_level = m[1:0];
      repeat (3 * P) @(negedge clk_sys);
      chk("mode", mode_of(m), {30'h0, mode_active});
    end
    @(negedge clk_sys);
    zero_cross = 2'h3;
    slow = 1;
    window(8);
    chk("forced pulses ch0", 8, r0);
    chk("forced pulses ch1", 8, r1);
    chk("phase", P / 2, ((t_rise[1] - t_rise[0]) % P + P) % P);
    @(negedge clk_sys);
    over_current = 2'h3;
    window(4);
    chk("oc pulses", 0, r0);
    chk("oc low gaps", 0, g0);
    @(negedge clk_sys);
    over_current = 0;
    mode_level = 2'h0;
    error_low = 2'h3;
    window(4);
    chk("skipped pulses", 0, r0);
    @(negedge clk_sys);
    error_low = 0;
    skip_limit = 2'h3;
    window(4);
    chk("auto pulses", 4, r0);
    chk("low released", 1, g0 > 0);
    chk("auto on-time", 1, on_max);
    @(negedge clk_sys);
    mode_level = 2'h1;
    window(4);
    chk("ultra pulses", 4, r0);
    chk("ultra on-time", 1, on_max);
    // light load in ultrasonic: only the idle timer starts pulses
    @(negedge clk_sys);
    error_low = 2'h3;
    window(8);
    chk("idle pulses", 1, r0 > 0);
    chk("idle rate", 1, r0 >= 2);
    chk("ultra low length", 1, lo_max <= 3);
    wrap_up();
  end
endmodule
